// ===== rtl/exc_check_map.svh
// register-free constant map for the request checker
// assumes inclusion by the checker module only
`ifndef EXC_CHECK_MAP_SVH
`define EXC_CHECK_MAP_SVH
`define EXC_FUNC_FLAG      8'h80
`define EXC_ILLEGAL_FUNC   8'h01
`define EXC_ILLEGAL_ADDR   8'h02
`define EXC_ILLEGAL_VALUE  8'h03
`define EXC_DEVICE_FAIL    8'h04
`define EXC_ACKNOWLEDGE    8'h05
`define EXC_DEVICE_BUSY    8'h06
`define EXC_NEG_ACK        8'h07
`define EXC_MEM_PARITY     8'h08
`define EXC_GW_PATH        8'h0A
`define EXC_GW_TARGET      8'h0B
`define PWD_DEFAULT_ADMIN  32'h30303030
`define PWD_DEFAULT_SERV   32'h31313131
`define PWD_DEFAULT_ENG    32'h32323232
`define PWD_DEFAULT_OPER   32'h33333333
`define PROFILE_ADMIN      2'h0
`define CHAR_DIGIT_LO      8'h30
`define CHAR_DIGIT_HI      8'h39
`define CHAR_UPPER_LO      8'h41
`define CHAR_UPPER_HI      8'h5A
`define CHAR_LOWER_LO      8'h61
`define CHAR_LOWER_HI      8'h7A
`define RESULT_OK          8'h00
`define RESULT_BAD_PWD     8'h01
`define RESULT_LOCKED      8'h02
`define RESULT_BAD_FORMAT  8'h03
`define RESULT_BAD_CHAR    8'h04
`endif

// ===== rtl/exc_check_pkg.sv
// types shared by the request checker and its bench
// assumes exc_check_map.svh on the include path
package exc_check_pkg;
   // failure causes of a received request, at most one reported
   typedef struct packed {
      logic comm_err;
      logic busy;
      logic bad_func;
      logic bad_addr;
      logic unimpl_reg;
      logic bad_value;
      logic dev_fail;
      logic slow_accept;
      logic prog_fail;
      logic mem_parity;
      logic gw_path;
      logic gw_target;
   } req_fault_t;

   typedef struct packed {
      logic [7:0] slave;
      logic [7:0] func;
      logic [7:0] code;
   } exc_frame_t;

   typedef struct packed {
      logic        intrusive;
      logic        well_formed;
      logic [3:0]  profiles;
      logic [31:0] password;
   } cmd_req_t;

   typedef struct packed {
      logic [1:0]  profile;
      logic [31:0] old_pwd;
      logic [31:0] new_pwd;
   } pwd_change_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_CHECK = 2'b01,
      ST_DONE  = 2'b10
   } cmd_state_t;
endpackage

// ===== rtl/exc_check.sv
// request checker: exception frame builder and password gate
// assumes a framer supplies decoded request faults and command fields;
// crc16 is appended by the transmitter that consumes exc_out
`timescale 1ns/10ps
`include "exc_check_map.svh"

module exc_check
   import exc_check_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        rst_b_in,
   input  wire logic        req_valid_in,
   input  wire logic [7:0]  req_slave_in,
   input  wire logic [7:0]  req_func_in,
   input  wire req_fault_t  req_fault_in,
   input  wire logic        cmd_valid_in,
   input  wire cmd_req_t    cmd_in,
   input  wire logic        hw_unlocked_in,
   input  wire logic        pwd_change_valid_in,
   input  wire pwd_change_t pwd_change_in,
   output logic             exc_valid_out,
   output exc_frame_t       exc_out,
   output logic             cmd_done_out,
   output logic             cmd_exec_out,
   output logic [7:0]       cmd_result_out,
   output logic             pwd_change_done_out,
   output logic             pwd_change_ok_out
);

   // ==========================================================
   // profile password storage
   logic [31:0] pwd_store [4];
   logic [3:0]  pwd_hit;
   logic        change_auth;
   logic        new_pwd_ok;

   function automatic logic char_ok(input logic [7:0] c);
      char_ok = (c >= `CHAR_DIGIT_LO && c <= `CHAR_DIGIT_HI)
             || (c >= `CHAR_UPPER_LO && c <= `CHAR_UPPER_HI)
             || (c >= `CHAR_LOWER_LO && c <= `CHAR_LOWER_HI);
   endfunction

   function automatic logic pwd_ok(input logic [31:0] p);
      pwd_ok = char_ok(p[31:24]) && char_ok(p[23:16])
            && char_ok(p[15:8]) && char_ok(p[7:0]);
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_prof
         // whole-word compare, bytes never checked one at a time
         assign pwd_hit[gi] = (cmd_in.password == pwd_store[gi]);
      end
   endgenerate

   assign change_auth = (pwd_change_in.old_pwd == pwd_store[pwd_change_in.profile])
                     || (pwd_change_in.old_pwd == pwd_store[`PROFILE_ADMIN]);
   assign new_pwd_ok  = pwd_ok(pwd_change_in.new_pwd);

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         pwd_store[0] <= `PWD_DEFAULT_ADMIN;
         pwd_store[1] <= `PWD_DEFAULT_SERV;
         pwd_store[2] <= `PWD_DEFAULT_ENG;
         pwd_store[3] <= `PWD_DEFAULT_OPER;
      end else if (pwd_change_valid_in && change_auth && new_pwd_ok) begin
         pwd_store[pwd_change_in.profile] <= pwd_change_in.new_pwd;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         pwd_change_done_out <= 1'b0;
         pwd_change_ok_out   <= 1'b0;
      end else begin
         pwd_change_done_out <= pwd_change_valid_in;
         pwd_change_ok_out   <= pwd_change_valid_in && change_auth && new_pwd_ok;
      end
   end

   // ==========================================================
   // command gate
   // three-state machine keeps one command in flight; a request seen
   // while it is busy gets the busy exception
   cmd_state_t state;
   cmd_state_t next_state;
   cmd_req_t   cmd_hold;
   logic [3:0] hit_hold;
   logic [7:0] next_result;

   always_comb begin
      case (state)
         ST_IDLE:  next_state = cmd_valid_in ? ST_CHECK : ST_IDLE;
         ST_CHECK: next_state = ST_DONE;
         ST_DONE:  next_state = ST_IDLE;
         default:  next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         cmd_hold <= '0;
         hit_hold <= 4'h0;
      end else if (state == ST_IDLE && cmd_valid_in) begin
         cmd_hold <= cmd_in;
         hit_hold <= pwd_hit & cmd_in.profiles;
      end
   end

   always_comb begin
      if (!cmd_hold.well_formed) begin
         next_result = `RESULT_BAD_FORMAT;
      end else if (!cmd_hold.intrusive) begin
         next_result = `RESULT_OK;
      end else if (!hw_unlocked_in) begin
         // lock checked after the format check but ahead of the password, so it wins over both password checks
         next_result = `RESULT_LOCKED;
      end else if (!pwd_ok(cmd_hold.password)) begin
         next_result = `RESULT_BAD_CHAR;
      end else if (hit_hold == 4'h0) begin
         next_result = `RESULT_BAD_PWD;
      end else begin
         next_result = `RESULT_OK;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         cmd_done_out   <= 1'b0;
         cmd_exec_out   <= 1'b0;
         cmd_result_out <= `RESULT_OK;
      end else begin
         cmd_done_out <= (state == ST_CHECK);
         cmd_exec_out <= (state == ST_CHECK) && (next_result == `RESULT_OK);
         if (state == ST_CHECK) begin
            cmd_result_out <= next_result;
         end
      end
   end

   // ==========================================================
   // exception frame builder
   logic       cmd_busy;
   logic [7:0] next_code;
   logic       next_exc;

   assign cmd_busy = (state != ST_IDLE);

   always_comb begin
      next_exc  = 1'b1;
      next_code = `EXC_ILLEGAL_FUNC;
      if (req_fault_in.busy || cmd_busy) begin
         next_code = `EXC_DEVICE_BUSY;
      end else if (req_fault_in.bad_func) begin
         next_code = `EXC_ILLEGAL_FUNC;
      end else if (req_fault_in.bad_addr || req_fault_in.unimpl_reg) begin
         next_code = `EXC_ILLEGAL_ADDR;
      end else if (req_fault_in.bad_value) begin
         next_code = `EXC_ILLEGAL_VALUE;
      end else if (req_fault_in.dev_fail) begin
         next_code = `EXC_DEVICE_FAIL;
      end else if (req_fault_in.prog_fail) begin
         next_code = `EXC_NEG_ACK;
      end else if (req_fault_in.mem_parity) begin
         next_code = `EXC_MEM_PARITY;
      end else if (req_fault_in.gw_path) begin
         next_code = `EXC_GW_PATH;
      end else if (req_fault_in.gw_target) begin
         next_code = `EXC_GW_TARGET;
      end else if (req_fault_in.slow_accept) begin
         next_code = `EXC_ACKNOWLEDGE;
      end else begin
         next_exc = 1'b0;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         exc_valid_out <= 1'b0;
         exc_out       <= '0;
      end else begin
         // corrupted frames stay silent; the master times out
         exc_valid_out <= req_valid_in && !req_fault_in.comm_err && next_exc;
         if (req_valid_in) begin
            exc_out.slave <= req_slave_in;
            exc_out.func  <= req_func_in | `EXC_FUNC_FLAG;
            exc_out.code  <= next_code;
         end
      end
   end

   // ==========================================================
   // checks
   a_func_flag_set: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      exc_valid_out |-> exc_out.func == ($past(req_func_in) | `EXC_FUNC_FLAG))
      else $error("exception function code lacks top bit");

   a_comm_err_quiet: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && req_fault_in.comm_err |=> !exc_valid_out)
      else $error("response sent for corrupted request");

   a_busy_code: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && !req_fault_in.comm_err && state != ST_IDLE
      |=> exc_valid_out && exc_out.code == `EXC_DEVICE_BUSY)
      else $error("busy request not answered with busy code");

   a_addr_code: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && state == ST_IDLE && !req_fault_in.comm_err && !req_fault_in.busy
      && !req_fault_in.bad_func && (req_fault_in.bad_addr || req_fault_in.unimpl_reg)
      |=> exc_valid_out && exc_out.code == `EXC_ILLEGAL_ADDR)
      else $error("unimplemented register not answered with address code");

   a_lock_wins: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      state == ST_CHECK && cmd_hold.intrusive && !hw_unlocked_in
      |=> !cmd_exec_out && cmd_done_out)
      else $error("intrusive command executed while locked");

   a_open_cmd: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      state == ST_IDLE && cmd_valid_in && cmd_in.well_formed && !cmd_in.intrusive
      |=> ##1 cmd_exec_out)
      else $error("non-intrusive command not executed");

   a_pwd_needed: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      state == ST_IDLE && cmd_valid_in && cmd_in.intrusive
      && ((pwd_hit & cmd_in.profiles) == 4'h0) |=> ##1 !cmd_exec_out)
      else $error("intrusive command executed with wrong password");

   a_change_auth: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      pwd_change_ok_out |-> $past(change_auth) && $past(pwd_change_valid_in))
      else $error("password changed without authority");

   a_new_pwd_chars: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      pwd_change_valid_in && !new_pwd_ok |=> !pwd_change_ok_out)
      else $error("password with illegal characters accepted");

   a_slave_echo: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      exc_valid_out |-> exc_out.slave == $past(req_slave_in))
      else $error("exception frame carries wrong slave number");

   a_func_code: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && state == ST_IDLE && $onehot(req_fault_in) && req_fault_in.bad_func
      |=> exc_valid_out && exc_out.code == `EXC_ILLEGAL_FUNC)
      else $error("illegal function not answered with its code");

   a_value_code: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && state == ST_IDLE && $onehot(req_fault_in) && req_fault_in.bad_value
      |=> exc_valid_out && exc_out.code == `EXC_ILLEGAL_VALUE)
      else $error("illegal value not answered with its code");

   a_fail_code: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && state == ST_IDLE && $onehot(req_fault_in) && req_fault_in.dev_fail
      |=> exc_valid_out && exc_out.code == `EXC_DEVICE_FAIL)
      else $error("device failure not answered with its code");

   a_ack_code: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && state == ST_IDLE && $onehot(req_fault_in) && req_fault_in.slow_accept
      |=> exc_valid_out && exc_out.code == `EXC_ACKNOWLEDGE)
      else $error("slow request not answered with acknowledge code");

   a_prog_code: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && state == ST_IDLE && $onehot(req_fault_in) && req_fault_in.prog_fail
      |=> exc_valid_out && exc_out.code == `EXC_NEG_ACK)
      else $error("failed programming not answered with its code");

   a_parity_code: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && state == ST_IDLE && $onehot(req_fault_in) && req_fault_in.mem_parity
      |=> exc_valid_out && exc_out.code == `EXC_MEM_PARITY)
      else $error("memory parity error not answered with its code");

   a_path_code: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && state == ST_IDLE && $onehot(req_fault_in) && req_fault_in.gw_path
      |=> exc_valid_out && exc_out.code == `EXC_GW_PATH)
      else $error("gateway path fault not answered with its code");

   a_target_code: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      req_valid_in && state == ST_IDLE && $onehot(req_fault_in) && req_fault_in.gw_target
      |=> exc_valid_out && exc_out.code == `EXC_GW_TARGET)
      else $error("absent gateway target not answered with its code");
endmodule

// ===== testbench/master_model.sv
// serial master model: issues decoded requests and captures replies
// assumes the bench calls send or retry and reads got and frame
`timescale 1ns/10ps
module master_model
   import exc_check_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        avail_in,
   input  wire logic        exc_valid_in,
   input  wire exc_frame_t  exc_in,
   output logic             req_valid_out,
   output logic [7:0]       req_slave_out,
   output logic [7:0]       req_func_out,
   output req_fault_t       req_fault_out
);
   // ==========================
   // request issue
   logic       got;
   exc_frame_t frame;
   initial begin
      req_valid_out = 1'b0;
      req_slave_out = 8'h00;
      req_func_out = 8'h00;
      req_fault_out = '0;
   end
   task automatic send(input logic [7:0] f, input req_fault_t flt);
      @(posedge clock_in);
      req_valid_out <= 1'b1;
      req_slave_out <= 8'h11;
      req_func_out <= f;
      req_fault_out <= flt;
      @(posedge clock_in);
      req_valid_out <= 1'b0;
      // released func and fault fields change so stale values cannot pass for live ones
      req_func_out <= ~f;
      req_fault_out <= ~flt;
      #1;
      got = exc_valid_in;
      frame = exc_in;
   endtask
   task automatic retry(input logic [7:0] f, input req_fault_t flt);
      int n;
      n = 0;
      while (avail_in !== 1'b1 && n < 20) begin
         @(posedge clock_in);
         #1;
         n++;
      end
      send(f, flt);
   endtask
endmodule

// ===== testbench/exc_check_bench.sv
// bench for the request checker: exception codes, busy retry, password gate
// assumes master_model stands in for the serial master
`timescale 1ns/10ps
module exc_check_bench
   import exc_check_pkg::*;
;
   // ==========================
   // harness
   logic        clock_in, rst_b_in, cmd_valid_in, hw_unlocked_in;
   logic        pwd_change_valid_in, req_valid_in, exc_valid_out;
   logic        cmd_done_out, cmd_exec_out, pwd_change_done_out, pwd_change_ok_out;
   logic [7:0]  req_slave_in, req_func_in, cmd_result_out;
   req_fault_t  req_fault_in;
   cmd_req_t    cmd_in;
   pwd_change_t pwd_change_in;
   exc_frame_t  exc_out;
   int          miscompares, cmp_count;
   logic [7:0]  codes [0:10] = '{8'h0B, 8'h0A, 8'h08, 8'h07, 8'h05, 8'h04,
                                 8'h03, 8'h02, 8'h02, 8'h01, 8'h06};
   exc_check uut (.clock_in(clock_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid_in),
      .req_slave_in(req_slave_in), .req_func_in(req_func_in), .req_fault_in(req_fault_in),
      .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .hw_unlocked_in(hw_unlocked_in),
      .pwd_change_valid_in(pwd_change_valid_in), .pwd_change_in(pwd_change_in),
      .exc_valid_out(exc_valid_out), .exc_out(exc_out), .cmd_done_out(cmd_done_out),
      .cmd_exec_out(cmd_exec_out), .cmd_result_out(cmd_result_out),
      .pwd_change_done_out(pwd_change_done_out), .pwd_change_ok_out(pwd_change_ok_out));
   master_model m (.clock_in(clock_in), .avail_in(cmd_done_out),
      .exc_valid_in(exc_valid_out), .exc_in(exc_out), .req_valid_out(req_valid_in),
      .req_slave_out(req_slave_in), .req_func_out(req_func_in),
      .req_fault_out(req_fault_in));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   function automatic cmd_req_t mk(int i, int w, logic [3:0] p, logic [31:0] pw);
      return {i[0], w[0], p, pw};
   endfunction
   task automatic go(input cmd_req_t c);
      @(posedge clock_in);
      cmd_valid_in <= 1'b1;
      cmd_in <= c;
      @(posedge clock_in);
      cmd_valid_in <= 1'b0;
      cmd_in <= ~c;
   endtask
   task automatic docmd(input cmd_req_t c, input int ex, input logic [7:0] res);
      int n;
      go(c);
      n = 0;
      do begin
         @(posedge clock_in);
         #1;
         n++;
      end while (cmd_done_out !== 1'b1 && n < 5);
      chk(cmd_done_out, 1'b1);
      chk(cmd_exec_out, ex);
      chk(cmd_result_out, res);
   endtask
   task automatic chg(input logic [1:0] p, input logic [31:0] o, n, input logic ok);
      @(posedge clock_in);
      pwd_change_valid_in <= 1'b1;
      pwd_change_in <= {p, o, n};
      @(posedge clock_in);
      pwd_change_valid_in <= 1'b0;
      pwd_change_in <= ~{p, o, n};
      #1;
      chk(pwd_change_done_out, 1'b1);
      chk(pwd_change_ok_out, ok);
   endtask
   // ==========================
   // scenarios
   task automatic t_codes();
      req_fault_t f;
      for (int i = 0; i < 11; i++) begin
         f = '0;
         f[i] = 1'b1;
         m.send(8'h03, f);
         chk(m.got, 1'b1);
         chk(m.frame, {8'h11, 8'h83, codes[i]});
      end
      m.send(8'h03, 12'h900);
      chk(m.got, 1'b0);
      m.send(8'h03, 12'h000);
      chk(m.got, 1'b0);
      $display("codes test done");
   endtask
   task automatic t_busy();
      fork
         go(mk(1'b0, 1'b1, 4'h0, 32'h0));
         begin
            @(posedge clock_in);
            m.send(8'h10, 12'h040);
         end
      join
      chk(m.frame[7:0], 8'h06);
      m.retry(8'h10, 12'h040);
      chk(m.frame, 24'h119003);
      chk(cmd_result_out, 8'h00);
      $display("busy test done");
   endtask
   task automatic t_cmd();
      for (int i = 0; i < 4; i++)
         docmd(mk(1, 1, 4'h1 << i, 32'h30303030 + i * 32'h01010101), 1, 8'h00);
      docmd(mk(1, 1, 4'h4, 32'h31313131), 0, 8'h01);
      docmd(mk(1, 0, 4'h1, 32'h30303030), 0, 8'h03);
      docmd(mk(1, 1, 4'h1, 32'h30302130), 0, 8'h04);
      docmd(mk(0, 1, 4'h0, 32'hFFFFFFFF), 1, 8'h00);
      @(posedge clock_in);
      hw_unlocked_in <= 1'b0;
      docmd(mk(1, 1, 4'h1, 32'h30303030), 0, 8'h02);
      @(posedge clock_in);
      hw_unlocked_in <= 1'b1;
      $display("command test done");
   endtask
   task automatic t_pwd();
      chg(2'h1, 32'h31313131, 32'h61624344, 1'b1);
      docmd(mk(1, 1, 4'h2, 32'h61624344), 1, 8'h00);
      docmd(mk(1, 1, 4'h2, 32'h61626364), 0, 8'h01);
      docmd(mk(1, 1, 4'h2, 32'h31313131), 0, 8'h01);
      chg(2'h3, 32'h30303030, 32'h7A5A3039, 1'b1);
      chg(2'h2, 32'h31313131, 32'h41414141, 1'b0);
      chg(2'h2, 32'h32323232, 32'h41412D41, 1'b0);
      docmd(mk(1, 1, 4'h4, 32'h32323232), 1, 8'h00);
      docmd(mk(1, 1, 4'h8, 32'h7A5A3039), 1, 8'h00);
      // mid-run reset must bring back the profile 1 default password
      @(posedge clock_in);
      rst_b_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      rst_b_in <= 1'b1;
      docmd(mk(1, 1, 4'h2, 32'h31313131), 1, 8'h00);
      $display("password test done");
   endtask
   initial begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end
   initial begin
      rst_b_in = 1'b0;
      hw_unlocked_in = 1'b1;
      cmd_valid_in = 1'b0;
      cmd_in = '0;
      pwd_change_valid_in = 1'b0;
      pwd_change_in = '0;
      repeat (3) @(posedge clock_in);
      rst_b_in <= 1'b1;
      t_codes();
      t_cmd();
      // after the locked verdict, so a stale result cannot pass
      t_busy();
      t_pwd();
      end_sim();
   end
   initial begin
      #20000;
      miscompares++;
      end_sim();
   end
endmodule
